// File: verilog/sdp_serial_port.v
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "sdp_defines.vh"

module sdp_serial_port (
   input  wire        clock,
   input  wire        nrst,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire [31:0] hrdata,
   output wire        hresp,
   input  wire        bclkIn,
   output wire        bclkOut,
   output wire        bclkOe,
   input  wire        lrclkIn,
   output wire        lrclkOut,
   output wire        lrclkOe,
   input  wire        sdataIn,
   output wire        sdataOut0,
   output wire        sdataOe0,
   output wire        sdataOut1,
   output wire        sdataOe1,
   output wire [7:0]  padDrive
);

   // ***************************************************************
   // register file
   // ***************************************************************
   reg  [7:0]  ctrl1_q;
   reg  [7:0]  ctrl2_q;
   reg  [7:0]  act_q;
   reg  [7:0]  start_q;
   reg  [7:0]  div_q;
   reg  [7:0]  pad_q;
   reg  [23:0] txMem_q [0:7];
   reg  [23:0] rxMem_q [0:7];
   reg         wrPend_q;
   reg  [7:0]  wrIdx_q;
   reg  [31:0] hrdata_q;
   reg  [31:0] rdMux;
   reg  [8:0]  halfLen_q;
   integer     i;

   wire        addrPhase = hsel & htrans[1] & hready;
   wire        addrOk    = (haddr[31:10] == 22'h0) & (haddr[1:0] == 2'h0);
   wire [7:0]  reqIdx    = addrOk ? haddr[9:2] : `SDP_IDX_NONE;

   wire [1:0]  mode   = ctrl1_q[`SDP_F_MODE];
   wire [1:0]  msbPos = ctrl1_q[`SDP_F_MSB];
   wire        fpol   = ctrl2_q[`SDP_F_FPOL];
   wire        ftype  = ctrl2_q[`SDP_F_FTYPE];
   wire        bedge  = ctrl2_q[`SDP_F_BEDGE];
   wire        master = ctrl2_q[`SDP_F_MASTER];
   wire        triEn  = ctrl2_q[`SDP_F_TRI];
   wire        tdm    = (mode != `SDP_MODE_2CH);

   // zero wait states; the only error source would be unmapped space,
   // which reads zero and ignores writes instead
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;
   assign padDrive  = pad_q;

   always @* begin
      rdMux = 32'h0;
      case (reqIdx)
         `SDP_IDX_CTRL1: rdMux = {24'h0, ctrl1_q};
         `SDP_IDX_CTRL2: rdMux = {24'h0, ctrl2_q};
         `SDP_IDX_ACT:   rdMux = {24'h0, act_q};
         `SDP_IDX_START: rdMux = {24'h0, start_q};
         `SDP_IDX_DIV:   rdMux = {24'h0, div_q};
         `SDP_IDX_PAD:   rdMux = {24'h0, pad_q};
         `SDP_IDX_STAT:  rdMux = {22'h0, master, halfLen_q};
         default: begin
            if (reqIdx[7:3] == `SDP_IDX_TX)
               rdMux = {8'h0, txMem_q[reqIdx[2:0]]};
            else if (reqIdx[7:3] == `SDP_IDX_RX)
               rdMux = {8'h0, rxMem_q[reqIdx[2:0]]};
            else
               rdMux = 32'h0;
         end
      endcase
   end

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wrPend_q <= 1'b0;
         wrIdx_q  <= `SDP_IDX_NONE;
         hrdata_q <= 32'h0;
      end else begin
         wrPend_q <= addrPhase & hwrite;
         wrIdx_q  <= reqIdx;
         if (addrPhase & ~hwrite)
            hrdata_q <= rdMux;
      end
   end

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ctrl1_q <= `SDP_RST_REG;
         ctrl2_q <= `SDP_RST_REG;
         act_q   <= `SDP_RST_ACT;
         start_q <= `SDP_RST_REG;
         div_q   <= `SDP_RST_DIV;
         pad_q   <= `SDP_RST_REG;
         for (i = 0; i < 8; i = i + 1)
            txMem_q[i] <= 24'h0;
      end else if (wrPend_q) begin
         case (wrIdx_q)
            `SDP_IDX_CTRL1: ctrl1_q <= hwdata[7:0];
            `SDP_IDX_CTRL2: ctrl2_q <= hwdata[7:0];
            `SDP_IDX_ACT:   act_q   <= hwdata[7:0];
            `SDP_IDX_START: start_q <= hwdata[7:0];
            `SDP_IDX_DIV:   div_q   <= hwdata[7:0];
            `SDP_IDX_PAD:   pad_q   <= hwdata[7:0];
            default: begin
               if (wrIdx_q[7:3] == `SDP_IDX_TX)
                  txMem_q[wrIdx_q[2:0]] <= hwdata[23:0];
            end
         endcase
      end
   end

   // ***************************************************************
   // pin synchronisers
   // ***************************************************************
   // the link clocks are unrelated to clock, so every pin is resampled
   reg  [1:0] bclkS_q;
   reg  [1:0] lrS_q;
   reg  [1:0] sdS_q;

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         bclkS_q <= 2'h0;
         lrS_q   <= 2'h0;
         sdS_q   <= 2'h0;
      end else begin
         bclkS_q <= {bclkS_q[0], bclkIn};
         lrS_q   <= {lrS_q[0], lrclkIn};
         sdS_q   <= {sdS_q[0], sdataIn};
      end
   end

   // ***************************************************************
   // master clock generation
   // ***************************************************************
   reg  [7:0] divCnt_q;
   reg        bclkGen_q;
   reg        lrGen_q;
   reg  [7:0] genBit_q;

   wire [7:0] frmLast = (mode == `SDP_MODE_TDM8) ? `SDP_LAST_TDM8 :
                        (mode == `SDP_MODE_TDM4) ? `SDP_LAST_TDM4 : `SDP_LAST_2CH;
   wire [7:0] genNext = (genBit_q == frmLast) ? 8'h0 : genBit_q + 8'h1;
   wire       genHalf = (genNext <= {1'b0, frmLast[7:1]});

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         divCnt_q  <= 8'h0;
         bclkGen_q <= 1'b0;
         lrGen_q   <= 1'b0;
         genBit_q  <= 8'h0;
      end else if (!master) begin
         divCnt_q  <= 8'h0;
         bclkGen_q <= ~bedge;
         lrGen_q   <= ~fpol;
         genBit_q  <= frmLast;
      end else if (divCnt_q >= div_q) begin
         divCnt_q  <= 8'h0;
         bclkGen_q <= ~bclkGen_q;
         if (~bclkGen_q == bedge) begin
            genBit_q <= genNext;
            // pulse type marks only bit 0; otherwise half duty, left half first
            if (ftype)
               lrGen_q <= (genNext == 8'h0) ? fpol : ~fpol;
            else
               lrGen_q <= genHalf ? fpol : ~fpol;
         end
      end else begin
         divCnt_q <= divCnt_q + 8'h1;
      end
   end

   assign bclkOut  = master & bclkGen_q;
   assign lrclkOut = master & lrGen_q;
   assign bclkOe   = master;
   assign lrclkOe  = master;

   // ***************************************************************
   // bit position decode
   // ***************************************************************
   // returns {valid, slot[2:0], bit[4:0]} for a bit position in the frame
   function [8:0] slotDec;
      input [8:0] p;
      input       right;
      input [1:0] md;
      input       pulse;
      input [1:0] msb;
      input [8:0] hl;
      reg   [4:0] w;
      reg   [8:0] dly;
      reg   [8:0] d;
      reg         ok;
      reg   [2:0] s;
      begin
         // the MSB sits one bit after the boundary, on it, or a measured half
         // less the word; right justified needs one whole half to lock on
         w = (msb == `SDP_MSB_RJ16) ? `SDP_RJ16_BITS : `SDP_WORD_BITS;
         if (msb == `SDP_MSB_DLY1)
            dly = 9'h1;
         else if (msb == `SDP_MSB_DLY0)
            dly = 9'h0;
         else if (hl > {4'h0, w})
            dly = hl - {4'h0, w};
         else
            dly = 9'h0;
         d  = p - dly;
         ok = (p >= dly);
         if (md == `SDP_MODE_2CH && !pulse) begin
            s  = {2'h0, right};
            ok = ok && (d[8:5] == 4'h0) && (!msb[1] || d[4:0] < w);
         end else begin
            s  = d[7:5];
            ok = ok && !d[8] && ((md == `SDP_MODE_TDM8) ||
                 ({1'b0, s} < ((md == `SDP_MODE_TDM4) ? `SDP_SLOTS_TDM4
                                                      : `SDP_SLOTS_2CH)));
         end
         slotDec = {ok, s, d[4:0]};
      end
   endfunction

   // frame boundary: both edges for half-duty two-channel, else entry to active level
   function frmEdge;
      input now;
      input last;
      begin
         if (!tdm && !ftype)
            frmEdge = now ^ last;
         else
            frmEdge = (now == fpol) && (last != fpol);
      end
   endfunction

   // ***************************************************************
   // link timing
   // ***************************************************************
   reg        bclkPrev_q;
   reg        lrLast_q;
   reg  [8:0] pos_q;

   wire       bclkLvl = master ? bclkGen_q : bclkS_q[1];
   wire       lrLvl   = master ? lrGen_q : lrS_q[1];
   wire       bclkChg = bclkLvl ^ bclkPrev_q;
   wire       smpTick = bclkChg & (bclkLvl != bedge);
   wire       lchTick = bclkChg & (bclkLvl == bedge);
   wire       bnd     = frmEdge(lrLvl, lrLast_q);
   // pos saturates, so a missing frame clock never wraps into a false slot
   wire [8:0] posInc  = (pos_q == `SDP_POS_MAX) ? pos_q : pos_q + 9'h1;
   wire [8:0] posNext = bnd ? 9'h0 : posInc;
   wire [8:0] dec     = slotDec(posNext, lrLvl != fpol, mode, ftype, msbPos, halfLen_q);
   wire       decOk   = dec[8];
   wire [2:0] decSlot = dec[7:5];
   wire [4:0] decBit  = dec[4:0];
   wire [4:0] wordIdx = `SDP_WORD_TOP - decBit;
   wire       inWord  = (decBit < `SDP_WORD_BITS);

   // ***************************************************************
   // receive
   // ***************************************************************
   reg  [23:0] rxAcc_q;
   reg  [2:0]  rxSlot_q;
   reg         rxHave_q;

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         bclkPrev_q <= 1'b0;
         lrLast_q   <= 1'b0;
         pos_q      <= `SDP_POS_MAX;
         halfLen_q  <= 9'h0;
         rxAcc_q    <= 24'h0;
         rxSlot_q   <= 3'h0;
         rxHave_q   <= 1'b0;
         for (i = 0; i < 8; i = i + 1)
            rxMem_q[i] <= 24'h0;
      end else begin
         bclkPrev_q <= bclkLvl;
         if (smpTick) begin
            lrLast_q <= lrLvl;
            pos_q    <= posNext;
            if (bnd)
               halfLen_q <= posInc;
            if (decOk && decBit == 5'h0) begin
               // a slot is stored when the next one starts, so the last slot of a
               // frame reads as the previous frame's value until the next frame
               // begins
               if (rxHave_q)
                  rxMem_q[rxSlot_q] <= rxAcc_q;
               rxAcc_q  <= {sdS_q[1], 23'h0};
               rxSlot_q <= decSlot;
               rxHave_q <= 1'b1;
            end else if (decOk && inWord) begin
               rxAcc_q[wordIdx] <= sdS_q[1];
            end
         end
      end
   end

   // ***************************************************************
   // transmit
   // ***************************************************************
   reg         out0_q;
   reg         out1_q;
   reg         oe0_q;
   reg         oe1_q;

   wire [2:0]  ch0     = start_q[`SDP_F_START0] + decSlot;
   wire [2:0]  ch1     = start_q[`SDP_F_START1] + decSlot;
   wire [23:0] word0   = txMem_q[ch0];
   wire [23:0] word1   = txMem_q[ch1];
   wire        slotAct = act_q[decSlot];
   // an inactive slot that is driven sends zeros, never the stored word
   wire        drvBit  = decOk & inWord & slotAct;
   // unused bits and slots float only in TDM; two-channel streams always drive
   wire        drvOe   = !tdm || (decOk && inWord && (slotAct || !triEn));

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         out0_q <= 1'b0;
         out1_q <= 1'b0;
         oe0_q  <= 1'b0;
         oe1_q  <= 1'b0;
      end else if (lchTick) begin
         out0_q <= drvBit & word0[wordIdx];
         out1_q <= drvBit & word1[wordIdx];
         oe0_q  <= drvOe;
         oe1_q  <= drvOe;
      end
   end

   assign sdataOut0 = out0_q;
   assign sdataOut1 = out1_q;
   assign sdataOe0  = oe0_q;
   assign sdataOe1  = oe1_q;

endmodule // sdp_serial_port

// File: verilog/sdp_defines.vh
`ifndef SDP_DEFINES_VH
`define SDP_DEFINES_VH

// ***************************************************************
// register indices (byte address = index * 4)
// ***************************************************************
`define SDP_IDX_CTRL1    8'h32
`define SDP_IDX_CTRL2    8'h33
`define SDP_IDX_ACT      8'h34
`define SDP_IDX_START    8'h35
`define SDP_IDX_DIV      8'h36
`define SDP_IDX_STAT     8'h37
`define SDP_IDX_PAD      8'h4c
`define SDP_IDX_TX       5'h0a
`define SDP_IDX_RX       5'h0b
`define SDP_IDX_NONE     8'hff

// ***************************************************************
// field positions
// ***************************************************************
`define SDP_F_MODE       1:0
`define SDP_F_MSB        3:2
`define SDP_F_FPOL       0
`define SDP_F_FTYPE      1
`define SDP_F_BEDGE      2
`define SDP_F_MASTER     3
`define SDP_F_TRI        4
`define SDP_F_START0     2:0
`define SDP_F_START1     6:4

// ***************************************************************
// codes
// ***************************************************************
`define SDP_MODE_2CH     2'h0
`define SDP_MODE_TDM4    2'h1
`define SDP_MODE_TDM8    2'h2
`define SDP_MSB_DLY1     2'h0
`define SDP_MSB_DLY0     2'h1
`define SDP_MSB_RJ16     2'h3

// ***************************************************************
// reset values and sizes
// ***************************************************************
`define SDP_RST_REG      8'h00
`define SDP_RST_ACT      8'hff
`define SDP_RST_DIV      8'h03
`define SDP_WORD_BITS    5'h18
`define SDP_RJ16_BITS    5'h10
`define SDP_WORD_TOP     5'h17
`define SDP_LAST_2CH     8'h3f
`define SDP_LAST_TDM4    8'h7f
`define SDP_LAST_TDM8    8'hff
`define SDP_SLOTS_2CH    4'h2
`define SDP_SLOTS_TDM4   4'h4
`define SDP_POS_MAX      9'h1ff

`endif

// File: tb/sdp_serial_port_assertions.sv
`timescale 1ns/1ps
module sdp_serial_port_assertions (
   input logic        clock,
   input logic        nrst,
   input logic        hsel,
   input logic [31:0] haddr,
   input logic [1:0]  htrans,
   input logic        hwrite,
   input logic [31:0] hwdata,
   input logic        hready,
   input logic        hreadyout,
   input logic [31:0] hrdata,
   input logic        hresp,
   input logic        bclkOut,
   input logic        bclkOe,
   input logic        lrclkOut,
   input logic        lrclkOe,
   input logic [7:0]  padDrive
);
   logic [31:0] addr_q;
   logic        wr_q, rd_q, mst_q, lrPrev_q, lrSeen_q, lrOe_q;
   logic [8:0]  lrCnt_q;
   // the step of lrclkOut when the enable rises is no frame edge
   wire         lrEdge = lrOe_q && lrclkOe && (lrclkOut != lrPrev_q);
   wire         take = hsel & htrans[1] & hready;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   // ***
   // bus snoop; the frame counter skips the first, possibly partial, half
   // ***
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         addr_q <= 32'h0;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         mst_q <= 1'b0;
         lrPrev_q <= 1'b0;
         lrSeen_q <= 1'b0;
         lrOe_q <= 1'b0;
         lrCnt_q <= 9'h0;
      end else begin
         lrOe_q <= lrclkOe;
         wr_q <= take & hwrite;
         rd_q <= take & ~hwrite;
         if (take) addr_q <= haddr;
         if (wr_q && addr_q == 32'hcc) mst_q <= hwdata[3];
         lrPrev_q <= lrclkOut;
         lrSeen_q <= lrclkOe & (lrSeen_q | lrEdge);
         lrCnt_q <= lrEdge ? 9'h0 : lrCnt_q + 9'h1;
      end
   end
   AST_BUS_OK: assert property (hreadyout && !hresp)
      else $error("bus answer not zero wait okay");
   AST_PAD_WR: assert property (wr_q && addr_q == 32'h130 |=>
      {24'h0, padDrive} == ($past(hwdata) & 32'hff)) else $error("pad write lost");
   AST_PAD_HOLD: assert property (!(wr_q && addr_q == 32'h130) |=> $stable(padDrive))
      else $error("pad changed without write");
   AST_PAD_RD: assert property (rd_q && addr_q == 32'h130 |-> hrdata == {24'h0, padDrive})
      else $error("pad read wrong");
   AST_NO_MAP: assert property (rd_q && addr_q == 32'h100 |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
   AST_OE_PAIR: assert property (bclkOe == lrclkOe)
      else $error("clock enables differ");
   AST_OE_MASTER: assert property ($stable(mst_q) |-> bclkOe == mst_q)
      else $error("clock enable not following master bit");
   AST_BCLK_HI: assert property (bclkOe && $rose(bclkOut) |-> bclkOut [*4] ##1 !bclkOut)
      else $error("bit clock high half wrong");
   AST_BCLK_LO: assert property (bclkOe && $fell(bclkOut) |-> !bclkOut [*4] ##1 bclkOut)
      else $error("bit clock low half wrong");
   AST_FRAME: assert property (lrclkOe && lrSeen_q && lrEdge |-> lrCnt_q == 9'hff)
      else $error("frame half not 32 bits");
   cover property (wr_q && addr_q == 32'hcc);
   cover property (bclkOe && $rose(bclkOut));
   cover property (lrclkOe && lrSeen_q && lrEdge);
endmodule // sdp_serial_port_assertions

// File: tb/sdp_link_partner.sv
`timescale 1ns/1ps
module sdp_link_partner (
   output logic bclk,
   output logic lrclk,
   output logic sdata,
   input  wire  sout,
   input  wire  sout1
);
   logic [23:0] cap [2];
   logic [31:0] tcap0 [8];
   logic [31:0] tcap1 [8];
   initial begin
      bclk = 1'b0;
      lrclk = 1'b1;
      sdata = 1'b0;
   end
   // ***
   // three 64-bit frames at 800 ns; bit clock stands still between runs
   // ***
   task run(input logic pol, input int dly, input logic [23:0] l, input logic [23:0] r);
      int idx;
      lrclk = ~pol;
      #437;
      for (int f = 0; f < 3; f++) begin
         for (int ch = 0; ch < 2; ch++) begin
            for (int b = 0; b < 32; b++) begin
               idx = b - dly;
               bclk = 1'b0;
               lrclk = (ch == 0) ? pol : ~pol;
               // bits outside the word toggle so a stale level never matches
               sdata = (idx >= 0 && idx < 24) ? (ch == 0 ? l[23-idx] : r[23-idx]) : ~sdata;
               #400;
               bclk = 1'b1;
               if (idx >= 0 && idx < 24) cap[ch][23-idx] = sout;
               #400;
            end
         end
      end
      bclk = 1'b0;
   endtask
   // ***
   // three frames of n 32-bit slots, MSB one bit after the frame start
   // ***
   task tdm(input logic pulse, input int n);
      int j;
      logic [23:0] w;
      lrclk = 1'b0;
      #437;
      for (int f = 0; f < 3; f++) begin
         for (int s = 0; s < 8; s++) begin
            tcap0[s] = 32'hzzzzzzzz;
            tcap1[s] = 32'hzzzzzzzz;
         end
         for (int p = 0; p < 32 * n; p++) begin
            j = p - 1;
            bclk = 1'b0;
            lrclk = pulse ? (p == 0) : (p < 16 * n);
            if (j >= 0 && j % 32 < 24) begin
               w = {4'h6, 4'(j / 32), 16'hc3a5};
               sdata = w[23 - j % 32];
            end else begin
               sdata = ~sdata;
            end
            #400;
            bclk = 1'b1;
            if (j >= 0) begin
               tcap0[j / 32][31 - j % 32] = sout;
               tcap1[j / 32][31 - j % 32] = sout1;
            end
            #400;
         end
      end
      bclk = 1'b0;
   endtask
endmodule // sdp_link_partner

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
   logic        clock = 1'b0;
   logic        nrst = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] rd;
   wire  [31:0] hrdata;
   wire  [7:0]  padDrive;
   wire         hreadyout, hresp, bclkOut, bclkOe, lrclkOut, lrclkOe;
   wire         sdataOut0, sdataOe0, sdataOut1, sdataOe1, pBclk, pLrclk, pSdata;
   wire         bclkPin = bclkOe ? bclkOut : pBclk;
   wire         lrclkPin = lrclkOe ? lrclkOut : pLrclk;
   wire         soutPin = sdataOe0 ? sdataOut0 : 1'bz;
   wire         sout1Pin = sdataOe1 ? sdataOut1 : 1'bz;
   int          miscompares = 0;
   int          compares = 0;
   always #50 clock = ~clock;
   sdp_serial_port u_dut (
      .clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .bclkIn(bclkPin),
      .bclkOut(bclkOut), .bclkOe(bclkOe), .lrclkIn(lrclkPin), .lrclkOut(lrclkOut),
      .lrclkOe(lrclkOe), .sdataIn(pSdata), .sdataOut0(sdataOut0), .sdataOe0(sdataOe0),
      .sdataOut1(sdataOut1), .sdataOe1(sdataOe1), .padDrive(padDrive));
   sdp_link_partner u_part (.bclk(pBclk), .lrclk(pLrclk), .sdata(pSdata), .sout(soutPin),
                            .sout1(sout1Pin));
   // ***
   // shared tasks
   // ***
   task final_report;
      if (miscompares == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 50);
      rd = hrdata;
      if (n >= 50) begin
         miscompares++;
         final_report;
      end
   endtask
   // ***
   // scenarios
   // ***
   task t_regs;
      logic [31:0] adr [6] = '{32'hc8, 32'hcc, 32'hd0, 32'hd4, 32'hd8, 32'h130};
      logic [7:0]  rstVal [6] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h03, 8'h00};
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, adr[i], 32'h0);
         chk(rd, {24'h0, rstVal[i]});
      end
      bus(1'b1, 32'h130, 32'h5a);
      bus(1'b0, 32'h130, 32'h0);
      chk(rd, 32'h5a);
      bus(1'b1, 32'h100, 32'hffffffff);
      bus(1'b0, 32'h100, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, 32'hd0, 32'ha5);
      bus(1'b0, 32'hd0, 32'h0);
      chk(rd, 32'ha5);
      bus(1'b1, 32'hd0, 32'hff);
   endtask
   // slave link run: transmit and left receive checked on the last frame, right receive on the second
   task t_fmt(input logic [31:0] c1, input logic [31:0] c2, input logic pol, input int dly,
              input logic [23:0] l, input logic [23:0] r);
      bus(1'b1, 32'hc8, c1);
      bus(1'b1, 32'hcc, c2);
      bus(1'b1, 32'h140, {8'h0, r});
      bus(1'b1, 32'h144, {8'h0, l});
      u_part.run(pol, dly, l, r);
      chk({8'h0, u_part.cap[0]}, {8'h0, r});
      chk({8'h0, u_part.cap[1]}, {8'h0, l});
      bus(1'b0, 32'h160, 32'h0);
      chk(rd & 32'hffffff, {8'h0, l});
      bus(1'b0, 32'h164, 32'h0);
      chk(rd & 32'hffffff, {8'h0, r});
   endtask
   // slave slot run: start channels 3 and 5, slots 3 and 6 inactive
   task t_tdm(input logic [31:0] c1, input logic [31:0] c2, input int n);
      logic [3:0]  ch0, ch1;
      logic [31:0] e0, e1;
      logic [7:0]  act;
      act = 8'hb7;
      bus(1'b1, 32'hc8, c1);
      bus(1'b1, 32'hcc, c2);
      bus(1'b1, 32'hd0, {24'h0, act});
      bus(1'b1, 32'hd4, 32'h53);
      for (int k = 0; k < 8; k++)
         bus(1'b1, 32'h140 + 4 * k, {8'h0, 4'ha, 4'(k), 16'h3c96});
      u_part.tdm(c2[1], n);
      for (int s = 0; s < n; s++) begin
         ch0 = 4'((s + 3) % 8);
         ch1 = 4'((s + 5) % 8);
         e0 = {4'ha, ch0, 16'h3c96, 8'hzz};
         e1 = {4'ha, ch1, 16'h3c96, 8'hzz};
         if (!act[s]) begin
            e0 = c2[4] ? 32'hzzzzzzzz : 32'h000000zz;
            e1 = e0;
         end
         if (n == 2) begin
            chk({8'h0, u_part.tcap0[s][31:8]}, {8'h0, e0[31:8]});
            chk({8'h0, u_part.tcap1[s][31:8]}, {8'h0, e1[31:8]});
         end else begin
            chk(u_part.tcap0[s], e0);
            chk(u_part.tcap1[s], e1);
         end
         bus(1'b0, 32'h160 + 4 * s, 32'h0);
         chk(rd, {8'h0, 4'h6, 4'(s), 16'hc3a5});
      end
   endtask
   task t_master;
      bus(1'b1, 32'hcc, 32'h8);
      repeat (2) @(posedge clock);
      chk({30'h0, bclkOe, lrclkOe}, 32'h3);
      repeat (900) @(posedge clock);
      bus(1'b0, 32'hdc, 32'h0);
      chk(rd & 32'h200, 32'h200);
   endtask
   initial begin
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      t_regs;
      t_fmt(32'h0, 32'h0, 1'b0, 1, 24'h9b1d57, 24'h2468ac);
      t_fmt(32'h4, 32'h1, 1'b1, 0, 24'h3c5a69, 24'ha5c3e1);
      t_fmt(32'h8, 32'h1, 1'b1, 8, 24'h800001, 24'h7ffffe);
      t_tdm(32'h2, 32'h11, 8);
      t_tdm(32'h1, 32'h11, 4);
      t_tdm(32'h2, 32'h3, 8);
      t_tdm(32'h0, 32'h3, 2);
      t_master;
      final_report;
   end
endmodule // tb
bind sdp_serial_port sdp_serial_port_assertions u_chk (
   .clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hrdata(hrdata), .hresp(hresp), .bclkOut(bclkOut), .bclkOe(bclkOe),
   .lrclkOut(lrclkOut), .lrclkOe(lrclkOe), .padDrive(padDrive));
